//--- shared/hipc_pkg.sv
// Purpose: Constants and types for the hub identity and power config bank.
// Assumes: Byte-wide configuration path, one core clock.
// Notes:   Register map, write request and identity types follow.
package hipc_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] HIPC_VID_LO_ADDR  = 8'h00;
    localparam logic [7:0] HIPC_VID_HI_ADDR  = 8'h01;
    localparam logic [7:0] HIPC_PID_LO_ADDR  = 8'h02;
    localparam logic [7:0] HIPC_PID_HI_ADDR  = 8'h03;
    localparam logic [7:0] HIPC_REL_LO_ADDR  = 8'h04;
    localparam logic [7:0] HIPC_REL_HI_ADDR  = 8'h05;
    localparam logic [7:0] HIPC_CFG1_ADDR    = 8'h06;
    localparam logic [7:0] HIPC_CFG2_ADDR    = 8'h07;
    localparam logic [7:0] HIPC_RESET_VALUE  = 8'h00;
    localparam int         HIPC_PWR_SEL_BIT  = 7;
    localparam int         HIPC_DYN_BIT      = 7;
    localparam int         HIPC_DESC_BYTES   = 6;

    // Write request from the serial configuration engines.
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } hipc_wr_t;

    // Assembled identity, low byte in bits 7:0 of each word.
    typedef struct packed {
        logic [15:0] vendor;
        logic [15:0] product;
        logic [15:0] release_bcd;
    } hipc_ident_t;

endpackage

//--- tb/hipc_loader.sv
// Purpose: Model of the serial loader (EEPROM reader or SMBus master).
// Assumes: One core clock; strobes are one-cycle pulses.
// Notes:   Idle address and data lines show the inverse of the last value.
module hipc_loader
    import hipc_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rvalid,
    input  wire logic [7:0] i_rdata,
    output logic            o_eeprom_wr,
    output logic            o_smbus_wr,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_wdata,
    output logic            o_rd
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_eeprom_wr = 1'b0;
        o_smbus_wr  = 1'b0;
        o_addr      = 8'h00;
        o_wdata     = 8'h00;
        o_rd        = 1'b0;
    end

    // ==========================================================
    // Byte write from either source; the caller gives the source, address and data.
    task automatic wr(input logic src, input logic [7:0] a,
                      input logic [7:0] d);
        @(posedge i_clk);
        o_eeprom_wr <= ~src;
        o_smbus_wr  <= src;
        o_addr      <= a;
        o_wdata     <= d;
        @(posedge i_clk);
        o_eeprom_wr <= 1'b0;
        o_smbus_wr  <= 1'b0;
        o_addr      <= ~a;
        o_wdata     <= ~d;
    endtask

    // ==========================================================
    // Byte read; the answer is waited for under a bounded count.
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output bit ok);
        ok = 1'b0;
        d  = 8'h00;
        @(posedge i_clk);
        o_rd   <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd   <= 1'b0;
        o_addr <= ~a;
        for (int n = 0; n < 8 && !ok; n++) begin
            #1;
            if (i_rvalid === 1'b1) begin
                d  = i_rdata;
                ok = 1'b1;
            end else begin
                @(posedge i_clk);
            end
        end
    endtask
endmodule

//--- tb/hipc_regs_test.sv
// Purpose: Self-checking bench of the identity and power config bank.
// Assumes: Loader model drives the write and read path.
// Notes:   A register model in integers gives every expected value.
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t value mismatch", $time); end end
module hipc_regs_test
    import hipc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk;
    logic        nrst = 1'b0;
    logic        ee_wr, sm_wr, rd, rvalid, selfp, bcd_ok;
    logic        pin  = 1'b0;
    logic [2:0]  idx  = 3'h0;
    logic [7:0]  addr, wdata, rdata, desc, rv;
    logic [47:0] ident;
    int          failures = 0;
    int          checked  = 0;
    int          m[8];
    bit          ok;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    hipc_regs u_hipc_regs (.I_REF_CLK(clk), .I_NRST(nrst),
        .i_eeprom_wr(ee_wr), .i_smbus_wr(sm_wr), .i_cfg_addr(addr),
        .i_cfg_wdata(wdata), .i_cfg_rd(rd), .i_local_supply_sense_pin(pin),
        .i_desc_index(idx), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
        .o_self_powered(selfp), .o_release_bcd_ok(bcd_ok),
        .o_desc_byte(desc), .o_ident(ident));

    hipc_loader u_ld (.i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata),
        .o_eeprom_wr(ee_wr), .o_smbus_wr(sm_wr), .o_addr(addr),
        .o_wdata(wdata), .o_rd(rd));

    // ==========================================================
    // Helpers
    task automatic results();
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic put(input int a, input int d);
        u_ld.wr(1'($urandom_range(0, 1)), 8'(a), 8'(d));
        if (a < 8) m[a] = d;
        settle(2);
    endtask

    task automatic get(input int a, output logic [7:0] d);
        u_ld.rd(8'(a), d, ok);
        if (!ok) begin
            failures++;
            results();
        end
    endtask

    function automatic logic bcd_exp();
        logic [15:0] r;
        r = {8'(m[5]), 8'(m[4])};
        return r[3:0] < 10 && r[7:4] < 10 && r[11:8] < 10 && r[15:12] < 10;
    endfunction

    function automatic logic pwr_exp();
        return m[7][7] ? pin : 1'(m[6][7]);
    endfunction

    task automatic check_all();
        logic [47:0] id_exp;
        for (int i = 0; i < 9; i++) begin
            get(i, rv);
            `CHK(rv, (i < 8) ? 8'(m[i]) : 8'h00)
        end
        id_exp = {8'(m[1]), 8'(m[0]), 8'(m[3]), 8'(m[2]), 8'(m[5]), 8'(m[4])};
        `CHK(ident, id_exp)
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            idx <= 3'(i);
            settle(2);
            `CHK(desc, (i < 6) ? 8'(m[i]) : 8'h00)
        end
        `CHK(bcd_ok, bcd_exp())
        `CHK(selfp, pwr_exp())
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(83));
        foreach (m[i]) m[i] = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        settle(1);
        check_all();
        for (int i = 0; i < 8; i++) put(i, $urandom_range(0, 255));
        put(7, 8'h00);
        put(6, 8'h80);
        put(8'h08, 8'h5a);
        check_all();
        put(4, 8'h34);
        put(5, 8'h12);
        check_all();
        put(4, 8'h3a);
        `CHK(bcd_ok, bcd_exp())
        for (int k = 0; k < 8; k++) begin
            put(7, (k > 3) ? 8'h80 : 8'h00);
            @(posedge clk);
            pin <= k[0];
            put(6, k[1] ? 8'h80 : 8'h00);
            settle(8);
            `CHK(selfp, pwr_exp())
        end
        // A reset in mid-run must clear every byte loaded so far.
        @(posedge clk);
        nrst <= 1'b0;
        foreach (m[i]) m[i] = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        settle(1);
        check_all();
        results();
    end

    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        results();
    end
endmodule

//--- verilog/hipc_regs.sv
// Purpose: Identity and power-select configuration bytes of the hub.
// Assumes: Writes arrive from the EEPROM loader or SMBus slave engine,
//          both in the core clock domain, one byte per request.
// Notes:   Descriptor bytes are read out by index, low byte first.
module hipc_regs
    import hipc_pkg::*;
(
    input  wire logic        I_REF_CLK,
    input  wire logic        I_NRST,
    input  wire logic        i_eeprom_wr,
    input  wire logic        i_smbus_wr,
    input  wire logic [7:0]  i_cfg_addr,
    input  wire logic [7:0]  i_cfg_wdata,
    input  wire logic        i_cfg_rd,
    input  wire logic        i_local_supply_sense_pin,
    input  wire logic [2:0]  i_desc_index,
    output logic [7:0]       o_cfg_rdata,
    output logic             o_cfg_rvalid,
    output logic             o_self_powered,
    output logic             o_release_bcd_ok,
    output logic [7:0]       o_desc_byte,
    output logic [47:0]      o_ident
);

    // ==========================================================
    // Register state
    logic [7:0]  vendor_code_low;
    logic [7:0]  vendor_code_high;
    logic [7:0]  product_code_low;
    logic [7:0]  product_code_high;
    logic [7:0]  release_bcd_low;
    logic [7:0]  release_bcd_high;
    logic [7:0]  hub_config_first_byte;
    logic [7:0]  hub_config_second_byte;
    logic [7:0]  next_vendor_code_low;
    logic [7:0]  next_vendor_code_high;
    logic [7:0]  next_product_code_low;
    logic [7:0]  next_product_code_high;
    logic [7:0]  next_release_bcd_low;
    logic [7:0]  next_release_bcd_high;
    logic [7:0]  next_cfg1;
    logic [7:0]  next_cfg2;
    hipc_wr_t    wr;
    hipc_ident_t ident;

    // Only the two serial configuration engines may write.
    always_comb begin
        wr.valid = i_eeprom_wr | i_smbus_wr;
        wr.addr  = i_cfg_addr;
        wr.data  = i_cfg_wdata;
    end

    function automatic logic hit(input hipc_wr_t w, input logic [7:0] a);
        hit = w.valid && (w.addr == a);
    endfunction

    function automatic logic bcd_ok(input logic [7:0] b);
        bcd_ok = (b[7:4] <= 4'h9) && (b[3:0] <= 4'h9);
    endfunction

    always_comb begin
        next_vendor_code_low   = vendor_code_low;
        next_vendor_code_high  = vendor_code_high;
        next_product_code_low  = product_code_low;
        next_product_code_high = product_code_high;
        next_release_bcd_low   = release_bcd_low;
        next_release_bcd_high  = release_bcd_high;
        next_cfg1              = hub_config_first_byte;
        next_cfg2              = hub_config_second_byte;
        if (hit(wr, HIPC_VID_LO_ADDR)) begin
            next_vendor_code_low = wr.data;
        end
        if (hit(wr, HIPC_VID_HI_ADDR)) begin
            next_vendor_code_high = wr.data;
        end
        if (hit(wr, HIPC_PID_LO_ADDR)) begin
            next_product_code_low = wr.data;
        end
        if (hit(wr, HIPC_PID_HI_ADDR)) begin
            next_product_code_high = wr.data;
        end
        if (hit(wr, HIPC_REL_LO_ADDR)) begin
            next_release_bcd_low = wr.data;
        end
        if (hit(wr, HIPC_REL_HI_ADDR)) begin
            next_release_bcd_high = wr.data;
        end
        if (hit(wr, HIPC_CFG1_ADDR)) begin
            next_cfg1 = wr.data;
        end
        if (hit(wr, HIPC_CFG2_ADDR)) begin
            next_cfg2 = wr.data;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            vendor_code_low        <= HIPC_RESET_VALUE;
            vendor_code_high       <= HIPC_RESET_VALUE;
            product_code_low       <= HIPC_RESET_VALUE;
            product_code_high      <= HIPC_RESET_VALUE;
            release_bcd_low        <= HIPC_RESET_VALUE;
            release_bcd_high       <= HIPC_RESET_VALUE;
            hub_config_first_byte  <= HIPC_RESET_VALUE;
            hub_config_second_byte <= HIPC_RESET_VALUE;
        end else begin
            vendor_code_low        <= next_vendor_code_low;
            vendor_code_high       <= next_vendor_code_high;
            product_code_low       <= next_product_code_low;
            product_code_high      <= next_product_code_high;
            release_bcd_low        <= next_release_bcd_low;
            release_bcd_high       <= next_release_bcd_high;
            hub_config_first_byte  <= next_cfg1;
            hub_config_second_byte <= next_cfg2;
        end
    end

    // ==========================================================
    // Power source, read-back and descriptor outputs
    logic        sense_s1;
    logic        sense_s2;
    logic        sense_s3;
    logic        sense_level;
    logic        next_sense_level;
    logic        next_self_powered;
    logic [7:0]  next_rdata;
    logic [7:0]  next_desc_byte;
    logic        power_source_select;
    logic        dyn_enable;

    // The sense pin is asynchronous; a change counts once stages two
    // and three agree, which also rejects single-cycle glitches.
    always_comb begin
        next_sense_level = sense_level;
        if (sense_s2 == sense_s3) begin
            next_sense_level = sense_s3;
        end
    end

    always_comb begin
        power_source_select = hub_config_first_byte[HIPC_PWR_SEL_BIT];
        dyn_enable          = hub_config_second_byte[HIPC_DYN_BIT];
        if (dyn_enable) begin
            next_self_powered = sense_level;
        end else begin
            next_self_powered = power_source_select;
        end
    end

    always_comb begin
        ident.vendor      = {vendor_code_high, vendor_code_low};
        ident.product     = {product_code_high, product_code_low};
        ident.release_bcd = {release_bcd_high, release_bcd_low};
    end

    // Descriptor order: vendor, product, release, each low byte first.
    always_comb begin
        case (i_desc_index)
            3'h0: next_desc_byte = vendor_code_low;
            3'h1: next_desc_byte = vendor_code_high;
            3'h2: next_desc_byte = product_code_low;
            3'h3: next_desc_byte = product_code_high;
            3'h4: next_desc_byte = release_bcd_low;
            3'h5: next_desc_byte = release_bcd_high;
            default: next_desc_byte = 8'h00;
        endcase
    end

    always_comb begin
        case (i_cfg_addr)
            HIPC_VID_LO_ADDR: next_rdata = vendor_code_low;
            HIPC_VID_HI_ADDR: next_rdata = vendor_code_high;
            HIPC_PID_LO_ADDR: next_rdata = product_code_low;
            HIPC_PID_HI_ADDR: next_rdata = product_code_high;
            HIPC_REL_LO_ADDR: next_rdata = release_bcd_low;
            HIPC_REL_HI_ADDR: next_rdata = release_bcd_high;
            HIPC_CFG1_ADDR:   next_rdata = hub_config_first_byte;
            HIPC_CFG2_ADDR:   next_rdata = hub_config_second_byte;
            default:          next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            sense_s1         <= 1'b0;
            sense_s2         <= 1'b0;
            sense_s3         <= 1'b0;
            sense_level      <= 1'b0;
            o_self_powered   <= 1'b0;
            o_cfg_rdata      <= 8'h00;
            o_cfg_rvalid     <= 1'b0;
            o_desc_byte      <= 8'h00;
            o_ident          <= 48'h0;
            o_release_bcd_ok <= 1'b1;
        end else begin
            sense_s1         <= i_local_supply_sense_pin;
            sense_s2         <= sense_s1;
            sense_s3         <= sense_s2;
            sense_level      <= next_sense_level;
            o_self_powered   <= next_self_powered;
            o_cfg_rdata      <= i_cfg_rd ? next_rdata : 8'h00;
            o_cfg_rvalid     <= i_cfg_rd;
            o_desc_byte      <= next_desc_byte;
            o_ident          <= ident;
            // BCD is the loader's duty; this flag only reports it.
            o_release_bcd_ok <= bcd_ok(release_bcd_low)
                              && bcd_ok(release_bcd_high);
        end
    end

    // ==========================================================
    // Assertions
    // A write reaches o_ident two edges after it is taken: the byte
    // lands in its register first and the assembled word follows.
    sequence s_vid_high_taken;
        hit(wr, HIPC_VID_HI_ADDR);
    endsequence

    sequence s_pid_low_taken;
        hit(wr, HIPC_PID_LO_ADDR);
    endsequence

    sequence s_sense_agreed;
        sense_s2 == sense_s3;
    endsequence

    a_vid_high_write: assert property (@(posedge I_REF_CLK)
        disable iff (!I_NRST)
        hit(wr, HIPC_VID_HI_ADDR) |=> vendor_code_high == $past(wr.data))
        else $error("vendor high byte not stored");

    a_pid_low_write: assert property (@(posedge I_REF_CLK)
        disable iff (!I_NRST)
        s_pid_low_taken |=> ##1 o_ident[23:16] == $past(wr.data, 2))
        else $error("product low byte not in ident");

    a_pid_high_write: assert property (@(posedge I_REF_CLK)
        disable iff (!I_NRST)
        hit(wr, HIPC_PID_HI_ADDR) |=> product_code_high == $past(wr.data))
        else $error("product high byte not stored");

    a_rel_low_write: assert property (@(posedge I_REF_CLK)
        disable iff (!I_NRST)
        hit(wr, HIPC_REL_LO_ADDR) |=> release_bcd_low == $past(wr.data))
        else $error("release low byte not stored");

    a_rel_high_hold: assert property (@(posedge I_REF_CLK)
        disable iff (!I_NRST)
        !hit(wr, HIPC_REL_HI_ADDR) |=> $stable(release_bcd_high))
        else $error("release high byte changed without write");

    a_static_power: assert property (@(posedge I_REF_CLK)
        disable iff (!I_NRST)
        !dyn_enable |=> o_self_powered == $past(power_source_select))
        else $error("static power select not followed");

    a_dynamic_power: assert property (@(posedge I_REF_CLK)
        disable iff (!I_NRST)
        dyn_enable |=> o_self_powered == $past(sense_level))
        else $error("dynamic power not from sense pin");

    a_no_path_write: assert property (@(posedge I_REF_CLK)
        disable iff (!I_NRST)
        !(i_eeprom_wr || i_smbus_wr) |=> $stable(hub_config_first_byte)
            && $stable(vendor_code_low))
        else $error("register changed without serial path write");

    a_desc_vid_low: assert property (@(posedge I_REF_CLK)
        disable iff (!I_NRST)
        i_desc_index == 3'h0 |=> o_desc_byte == $past(vendor_code_low))
        else $error("descriptor byte 0 is not vendor low");

    a_rd_answer: assert property (@(posedge I_REF_CLK)
        disable iff (!I_NRST)
        i_cfg_rd && i_cfg_addr == HIPC_VID_LO_ADDR
            |=> o_cfg_rvalid && o_cfg_rdata == $past(vendor_code_low))
        else $error("read-back of vendor low wrong");

    a_vid_low_write: assert property (@(posedge I_REF_CLK)
        disable iff (!I_NRST)
        hit(wr, HIPC_VID_LO_ADDR) |=> vendor_code_low == $past(wr.data))
        else $error("vendor low byte not stored");

    a_rel_high_write: assert property (@(posedge I_REF_CLK)
        disable iff (!I_NRST)
        hit(wr, HIPC_REL_HI_ADDR) |=> release_bcd_high == $past(wr.data))
        else $error("release high byte not stored");

    a_ident_vid_high: assert property (@(posedge I_REF_CLK)
        disable iff (!I_NRST)
        s_vid_high_taken |=> ##1 o_ident[47:40] == $past(wr.data, 2))
        else $error("vendor high byte not in ident");

    a_bcd_flag_low: assert property (@(posedge I_REF_CLK)
        disable iff (!I_NRST)
        release_bcd_low[3:0] > 4'h9 |=> !o_release_bcd_ok)
        else $error("bad release digit not flagged");

    a_sense_filter: assert property (@(posedge I_REF_CLK)
        disable iff (!I_NRST)
        s_sense_agreed |=> sense_level == $past(sense_s3))
        else $error("agreed sense level not taken");

    a_sense_hold: assert property (@(posedge I_REF_CLK)
        disable iff (!I_NRST)
        !(sense_s2 == sense_s3) |=> $stable(sense_level))
        else $error("sense level moved on disagreement");

    a_desc_rel_high: assert property (@(posedge I_REF_CLK)
        disable iff (!I_NRST)
        i_desc_index == 3'h5 |=> o_desc_byte == $past(release_bcd_high))
        else $error("descriptor byte 5 is not release high");

    a_rd_idle: assert property (@(posedge I_REF_CLK)
        disable iff (!I_NRST)
        !i_cfg_rd |=> !o_cfg_rvalid && o_cfg_rdata == 8'h00)
        else $error("read answer without read request");

endmodule
